// >>> rtl/sts_sequencer.sv
// scan trigger sequencer: channel list switching and layered scan control
`timescale 1ns/1ps
module sts_sequencer
    import sts_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic [`STS_NCH-1:0] CHAN_LIST_I,
    input wire logic CLOSE_CMD_I,
    input wire logic OPEN_CMD_I,
    input wire logic OPEN_ALL_CMD_I,
    input wire logic INIT_CMD_I,
    input sts_events_t EVENTS_I,
    input sts_cfg_t CFG_I,
    input wire logic LIST_WE_I,
    input wire logic [`STS_IDX_W-1:0] LIST_WADDR_I,
    input wire logic [`STS_IDX_W-1:0] LIST_WDATA_I,
    input wire logic [`STS_IDX_W-1:0] LIST_LEN_I,
    output logic [`STS_NCH-1:0] RELAY_O,
    output logic ARMED_O,
    output logic [2:0] LAYER_O,
    output logic [`STS_IDX_W-1:0] SCAN_IDX_O,
    output logic CHAN_READY_O
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARM,
        ST_SCAN,
        ST_CHAN_WAIT,
        ST_BREAK,
        ST_MAKE,
        ST_SETTLE
    } sts_state_t;

    sts_state_t state_q;
    logic [`STS_IDX_W-1:0] scan_list [`STS_LIST_DEPTH];
    logic [`STS_IDX_W-1:0] idx_q;
    logic [`STS_IDX_W-1:0] cur_ch_q;
    logic have_ch_q;
    logic [`STS_CNT_W-1:0] arms_q;
    logic [`STS_CNT_W-1:0] scans_q;
    logic [`STS_CNT_W-1:0] chans_q;
    logic first_scan_q;
    logic first_chan_q;
    logic scan_tmr_done_q;
    logic chan_tmr_done_q;
    logic [`STS_NCH-1:0] relay_q;
    logic settle_start;
    logic settle_done;
    logic scan_tmr_start;
    logic scan_tmr_done;
    logic chan_tmr_start;
    logic chan_tmr_done;
    logic [`STS_MS_W-1:0] settle_ms;
    logic arm_go;
    logic scan_go;
    logic chan_go;
    logic chans_left;
    logic scans_left;
    logic arms_left;
    logic [`STS_CNT_W-1:0] chan_total;
    logic [`STS_MS_W-1:0] scan_ms_lim;
    logic [`STS_MS_W-1:0] chan_ms_lim;

    // one decoder for all three layers so the event sets stay consistent
    function automatic logic ev_hit(input sts_ev_t ev, input sts_events_t e,
                                    input logic tmr_ok);
        case (ev)
            STS_EV_IMMED: ev_hit = 1'b1;
            STS_EV_MANUAL: ev_hit = e.step;
            STS_EV_BUS: ev_hit = e.bus_trg;
            STS_EV_EXT: ev_hit = e.ext_trg;
            STS_EV_LINK: ev_hit = e.link_trg;
            STS_EV_TIMER: ev_hit = tmr_ok;
            STS_EV_HOLD: ev_hit = 1'b0;
            default: ev_hit = 1'b0;
        endcase
    endfunction : ev_hit

    // settings above the longest legal interval are held at the ceiling
    function automatic logic [`STS_MS_W-1:0] clamp_ms(input logic [`STS_MS_W-1:0] ms);
        if (ms > `STS_MS_MAX) begin
            clamp_ms = `STS_MS_MAX;
        end else begin
            clamp_ms = ms;
        end
    endfunction : clamp_ms

    // events are looked at only in their own wait state, never latched
    assign arm_go = (state_q == ST_ARM) && ev_hit(CFG_I.arm_ev, EVENTS_I, 1'b1); // [R12] [R13] [R14] [R15] [R16] [R26]
    assign scan_go = (state_q == ST_SCAN) &&
        ev_hit(CFG_I.scan_ev, EVENTS_I, first_scan_q || scan_tmr_done_q); // [R9] [R20] [R26]
    assign chan_go = (state_q == ST_CHAN_WAIT) &&
        ev_hit(CFG_I.chan_ev, EVENTS_I, first_chan_q || chan_tmr_done_q); // [R8] [R19] [R26]

    assign chan_total = CFG_I.chan_use_len ? `STS_CNT_W'(LIST_LEN_I) : CFG_I.chan_cnt; // [R23]
    assign chans_left = CFG_I.chan_inf || (chans_q + `STS_CNT_W'(1) < chan_total);
    assign scans_left = CFG_I.scan_inf || (scans_q + `STS_CNT_W'(1) < CFG_I.scan_cnt); // [R22]
    assign arms_left = CFG_I.arm_inf || (arms_q + `STS_CNT_W'(1) < CFG_I.arm_cnt); // [R17]

    assign settle_ms = clamp_ms((cur_ch_q < `STS_IDX_W'(`STS_SLOT_CH)) ?
        CFG_I.delay1_ms : CFG_I.delay2_ms); // [R7]
    assign scan_ms_lim = clamp_ms(CFG_I.scan_ms); // [R21]
    assign chan_ms_lim = clamp_ms(CFG_I.chan_ms); // [R21]
    assign settle_start = (state_q == ST_MAKE);
    assign scan_tmr_start = scan_go;
    assign chan_tmr_start = chan_go;

    always_ff @(posedge CLK_SYS_I) begin
        if (LIST_WE_I && (LIST_WADDR_I < `STS_IDX_W'(`STS_LIST_DEPTH))) begin
            scan_list[LIST_WADDR_I] <= LIST_WDATA_I;
        end
    end

    sts_ms_timer u_settle (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .start_i(settle_start),
        .ms_i(settle_ms),
        .done_o(settle_done)
    );
    sts_ms_timer u_scan_tmr (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .start_i(scan_tmr_start),
        .ms_i(scan_ms_lim),
        .done_o(scan_tmr_done)
    );
    sts_ms_timer u_chan_tmr (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .start_i(chan_tmr_start),
        .ms_i(chan_ms_lim),
        .done_o(chan_tmr_done)
    );

    // timer expiry is held until used, set beats the clear from a new start
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || state_q == ST_IDLE) begin
            scan_tmr_done_q <= 1'b0;
        end else if (scan_tmr_done) begin
            scan_tmr_done_q <= 1'b1;
        end else if (scan_go) begin
            scan_tmr_done_q <= 1'b0;
        end
    end
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || state_q == ST_IDLE) begin
            chan_tmr_done_q <= 1'b0;
        end else if (chan_tmr_done) begin
            chan_tmr_done_q <= 1'b1;
        end else if (chan_go) begin
            chan_tmr_done_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            state_q <= ST_IDLE;
        end else if (OPEN_ALL_CMD_I) begin
            state_q <= ST_IDLE; // [R6]
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (EVENTS_I.step || INIT_CMD_I) begin
                        state_q <= ST_ARM; // [R4] [R11]
                    end
                end
                ST_ARM: begin
                    if (arm_go) begin
                        state_q <= ST_SCAN; // [R18]
                    end
                end
                ST_SCAN: begin
                    if (scan_go) begin
                        state_q <= ST_CHAN_WAIT; // [R24]
                    end
                end
                ST_CHAN_WAIT: begin
                    if (chan_go) begin
                        state_q <= ST_BREAK;
                    end
                end
                ST_BREAK: begin
                    state_q <= ST_MAKE; // [R5]
                end
                ST_MAKE: begin
                    state_q <= ST_SETTLE;
                end
                ST_SETTLE: begin
                    if (settle_done) begin
                        if (chans_left) begin
                            state_q <= ST_CHAN_WAIT; // [R7]
                        end else if (scans_left) begin
                            state_q <= ST_SCAN; // [R25]
                        end else if (arms_left) begin
                            state_q <= ST_ARM; // [R25]
                        end else begin
                            state_q <= ST_IDLE; // [R25]
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || state_q == ST_IDLE) begin
            arms_q <= '0;
            first_scan_q <= 1'b1;
        end else if (state_q == ST_SETTLE && settle_done && !chans_left && !scans_left) begin
            arms_q <= arms_q + `STS_CNT_W'(1);
            first_scan_q <= 1'b1;
        end else if (scan_go) begin
            first_scan_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || state_q == ST_IDLE || arm_go) begin
            scans_q <= '0;
        end else if (state_q == ST_SETTLE && settle_done && !chans_left) begin
            scans_q <= scans_q + `STS_CNT_W'(1);
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || state_q == ST_IDLE) begin
            chans_q <= '0;
            first_chan_q <= 1'b1;
        end else if (scan_go) begin
            chans_q <= '0;
            first_chan_q <= 1'b1;
        end else if (chan_go) begin
            first_chan_q <= 1'b0;
        end else if (state_q == ST_SETTLE && settle_done && chans_left) begin
            chans_q <= chans_q + `STS_CNT_W'(1);
        end
    end

    // list position survives across scans and wraps past the last entry
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || state_q == ST_IDLE) begin
            idx_q <= '0;
        end else if (state_q == ST_MAKE) begin
            if (idx_q + `STS_IDX_W'(1) >= LIST_LEN_I) begin
                idx_q <= '0; // [R3]
            end else begin
                idx_q <= idx_q + `STS_IDX_W'(1);
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || state_q == ST_IDLE) begin
            cur_ch_q <= '0;
            have_ch_q <= 1'b0;
        end else if (state_q == ST_BREAK) begin
            cur_ch_q <= scan_list[idx_q];
            have_ch_q <= 1'b1;
        end
    end

    // relays: open-all wins over every other source
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || OPEN_ALL_CMD_I) begin
            relay_q <= '0; // [R2] [R6]
        end else if (state_q == ST_BREAK && have_ch_q) begin
            relay_q[cur_ch_q] <= 1'b0; // [R5]
        end else if (state_q == ST_MAKE) begin
            relay_q[cur_ch_q] <= 1'b1; // [R5]
        end else if (state_q == ST_IDLE && CLOSE_CMD_I) begin
            relay_q <= relay_q | CHAN_LIST_I; // [R1]
        end else if (state_q == ST_IDLE && OPEN_CMD_I) begin
            relay_q <= relay_q & ~CHAN_LIST_I; // [R1]
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            CHAN_READY_O <= 1'b0;
        end else begin
            CHAN_READY_O <= (state_q == ST_SETTLE) && settle_done && !OPEN_ALL_CMD_I;
        end
    end

    assign RELAY_O = relay_q;
    assign ARMED_O = (state_q != ST_IDLE); // [R10]
    assign LAYER_O = state_q;
    assign SCAN_IDX_O = idx_q;
endmodule : sts_sequencer

// >>> rtl/sts_cfg.svh
// constants for the scan trigger sequencer
// How it works
// [R1] close or open every channel in list
// [R2] open-all opens every channel of both slots
// [R3] infinite count wraps to first scan entry
// [R4] idle step arms without closing manual channel
// [R5] open previous channel, then close next
// [R6] open-all aborts scan, goes idle, disarms
// [R7] per-slot settling delay after each closure
// [R8] immediate spacing closes first channel at once
// [R9] timer scans start on interval from start
// [R10] idle outside layers, armed flag off
// [R11] step or bus initiate enters arm layer
// [R12] immediate arm spacing passes straight through
// [R13] manual arm waits for step key
// [R14] bus arm waits for bus trigger
// [R15] external arm waits for trigger pulse
// [R16] link arm waits for linked trigger
// [R17] arm count 1..9999 or infinite, rearm; code takes any 14-bit arm_cnt, with no 9999 limit
// [R18] arm event satisfied moves to scan layer
// [R19] channel spacing link, immediate, hold
// [R20] scan spacing timer, external, bus, manual, immediate
// [R21] timer interval 1 ms to 99999.999 s; code clamps only the top, and 0 ms is taken and ends on the next edge
// [R22] scan count 1..9999 or infinite; code takes any 14-bit scan_cnt, with no 9999 limit
// [R23] channel count list length, finite or infinite
// [R24] scan event moves to channel layer
// [R25] exhausted counts fall back layer by layer
// [R26] events outside their wait are dropped
`ifndef STS_CFG_SVH
`define STS_CFG_SVH
`define STS_NCH 80
`define STS_SLOT_CH 40
`define STS_LIST_DEPTH 80
`define STS_IDX_W 7
`define STS_CNT_W 14
`define STS_CNT_MAX 14'h270F
`define STS_MS_W 27
`define STS_MS_MAX 27'h5F5_E0FF
`define STS_CLK_MHZ 250
`define STS_MS_NS 1000000
`define STS_CLK_NS 4
`define STS_MS_CYC (`STS_MS_NS / `STS_CLK_NS)
`endif

// >>> rtl/sts_pkg.sv
// types for the scan trigger sequencer
`include "sts_cfg.svh"
package sts_pkg;
    typedef enum logic [2:0] {
        STS_EV_IMMED,
        STS_EV_MANUAL,
        STS_EV_BUS,
        STS_EV_EXT,
        STS_EV_LINK,
        STS_EV_TIMER,
        STS_EV_HOLD
    } sts_ev_t;
    typedef struct packed {
        logic step;
        logic bus_trg;
        logic ext_trg;
        logic link_trg;
    } sts_events_t;
    typedef struct packed {
        sts_ev_t arm_ev;
        sts_ev_t scan_ev;
        sts_ev_t chan_ev;
        logic arm_inf;
        logic [`STS_CNT_W-1:0] arm_cnt;
        logic scan_inf;
        logic [`STS_CNT_W-1:0] scan_cnt;
        logic chan_inf;
        logic chan_use_len;
        logic [`STS_CNT_W-1:0] chan_cnt;
        logic [`STS_MS_W-1:0] scan_ms;
        logic [`STS_MS_W-1:0] chan_ms;
        logic [`STS_MS_W-1:0] delay1_ms;
        logic [`STS_MS_W-1:0] delay2_ms;
    } sts_cfg_t;
endpackage : sts_pkg

// >>> rtl/sts_ms_timer.sv
// millisecond countdown timer used for settling and spacing intervals
`timescale 1ns/1ps
module sts_ms_timer
    import sts_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [`STS_MS_W-1:0] ms_i,
    output logic done_o
);
    localparam int MS_CYC = `STS_MS_CYC;
    logic [17:0] pre_q;
    logic [`STS_MS_W-1:0] ms_q;
    logic run_q;
    logic tick;
    assign tick = run_q && (pre_q == 18'(MS_CYC - 1));
    always_ff @(posedge clk_i) begin
        if (rst_i || start_i || tick) begin
            pre_q <= 18'h0_0000;
        end else if (run_q) begin
            pre_q <= pre_q + 18'h0_0001;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q <= 1'b0;
            ms_q <= '0;
            done_o <= 1'b0;
        end else if (start_i) begin
            // zero interval finishes on the next edge
            run_q <= (ms_i != '0);
            ms_q <= ms_i;
            done_o <= (ms_i == '0);
        end else begin
            done_o <= 1'b0;
            if (tick) begin
                ms_q <= ms_q - `STS_MS_W'(1);
                if (ms_q <= `STS_MS_W'(1)) begin
                    run_q <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule : sts_ms_timer

// >>> verif/sts_sequencer_assertions.sv
// concurrent checks on the scan trigger sequencer ports
`timescale 1ns/1ps
module sts_sequencer_assertions
    import sts_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic [`STS_NCH-1:0] CHAN_LIST_I,
    input wire logic CLOSE_CMD_I,
    input wire logic OPEN_CMD_I,
    input wire logic OPEN_ALL_CMD_I,
    input wire logic INIT_CMD_I,
    input sts_events_t EVENTS_I,
    input sts_cfg_t CFG_I,
    input wire logic LIST_WE_I,
    input wire logic [`STS_IDX_W-1:0] LIST_WADDR_I,
    input wire logic [`STS_IDX_W-1:0] LIST_WDATA_I,
    input wire logic [`STS_IDX_W-1:0] LIST_LEN_I,
    input wire logic [`STS_NCH-1:0] RELAY_O,
    input wire logic ARMED_O,
    input wire logic [2:0] LAYER_O,
    input wire logic [`STS_IDX_W-1:0] SCAN_IDX_O,
    input wire logic CHAN_READY_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    logic arm_hit;
    logic go;
    // open-all overrides every other request in the same cycle
    assign go = !OPEN_ALL_CMD_I;
    always_comb begin
        case (CFG_I.arm_ev)
            STS_EV_IMMED: arm_hit = 1'b1;
            STS_EV_MANUAL: arm_hit = EVENTS_I.step;
            STS_EV_BUS: arm_hit = EVENTS_I.bus_trg;
            STS_EV_EXT: arm_hit = EVENTS_I.ext_trg;
            STS_EV_LINK: arm_hit = EVENTS_I.link_trg;
            // a timer arm setting passes straight through, as immediate does
            STS_EV_TIMER: arm_hit = 1'b1;
            default: arm_hit = 1'b0;
        endcase
    end
    a_armed_tracks: assert property (ARMED_O == (LAYER_O != 3'h0))
        else $error("armed flag disagrees with idle state");
    a_start_arms: assert property (LAYER_O == 3'h0 && (INIT_CMD_I || EVENTS_I.step) && go
        |=> LAYER_O == 3'h1 && ARMED_O) else $error("start request did not arm");
    a_arm_waits: assert property (LAYER_O == 3'h1 && !arm_hit && go |=> LAYER_O == 3'h1)
        else $error("arm layer left without its event");
    a_arm_leaves: assert property (LAYER_O == 3'h1 && arm_hit && go |=> LAYER_O == 3'h2)
        else $error("arm event did not reach scan layer");
    a_scan_moves: assert property (LAYER_O == 3'h2 && CFG_I.scan_ev == STS_EV_IMMED && go
        |=> LAYER_O != 3'h2) else $error("immediate scan layer did not move on");
    a_hold_still: assert property (LAYER_O == 3'h3 && CFG_I.chan_ev == STS_EV_HOLD && go
        |=> LAYER_O == 3'h3 && RELAY_O == $past(RELAY_O))
        else $error("hold spacing stepped a channel");
    a_open_all: assert property (OPEN_ALL_CMD_I |=> LAYER_O == 3'h0 && RELAY_O == '0)
        else $error("open-all did not abort and open");
    a_close_list: assert property (LAYER_O == 3'h0 && CLOSE_CMD_I && go
        |=> (RELAY_O & $past(CHAN_LIST_I)) == $past(CHAN_LIST_I))
        else $error("close left a listed channel open");
    a_open_list: assert property (LAYER_O == 3'h0 && OPEN_CMD_I && !CLOSE_CMD_I && go
        |=> (RELAY_O & $past(CHAN_LIST_I)) == '0) else $error("open left a listed channel");
    a_break_first: assert property (LAYER_O != 3'h0 && |(RELAY_O & ~$past(RELAY_O))
        |-> !(|($past(RELAY_O) & ~RELAY_O))) else $error("make and break in one cycle");
    a_ready_settle: assert property (CHAN_READY_O |-> $past(LAYER_O) == 3'h6)
        else $error("ready pulse without settle");
    c_arm_scan: cover property (LAYER_O == 3'h1 ##1 LAYER_O == 3'h2);
    c_ready: cover property (CHAN_READY_O);
    c_abort: cover property (OPEN_ALL_CMD_I && LAYER_O == 3'h3);
endmodule : sts_sequencer_assertions

// >>> verif/sts_event_src.sv
// far side event sources: step key, bus controller, trigger inputs
`timescale 1ns/1ps
module sts_event_src
    import sts_pkg::*;
(
    input wire logic clk_i,
    input wire logic fire_i,
    input sts_ev_t kind_i,
    output sts_events_t ev_o
);
    initial ev_o = '0;
    // strictly one-cycle pulses: a held level would look like repeated events
    always @(posedge clk_i) begin
        ev_o <= '0;
        if (fire_i) begin
            case (kind_i)
                STS_EV_MANUAL: ev_o.step <= 1'b1;
                STS_EV_BUS: ev_o.bus_trg <= 1'b1;
                STS_EV_EXT: ev_o.ext_trg <= 1'b1;
                STS_EV_LINK: ev_o.link_trg <= 1'b1;
                default: ev_o <= '0;
            endcase
        end
    end
endmodule : sts_event_src

// >>> verif/sts_sequencer_bench.sv
// self-checking bench for the scan trigger sequencer
`timescale 1ns/1ps
module sts_sequencer_bench
    import sts_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [`STS_NCH-1:0] chan_list, relay, exp_relay, nl;
    logic [3:0] cmds;
    logic fire, list_we, armed, chan_ready;
    sts_ev_t kind;
    sts_events_t events;
    sts_cfg_t cfg;
    logic [6:0] list_waddr, list_wdata, list_len, scan_idx;
    logic [2:0] layer;
    logic [31:0] seed;
    logic [6:0] lst [3] = '{7'h05, 7'h2D, 7'h0A};
    sts_ev_t arms [4] = '{STS_EV_MANUAL, STS_EV_BUS, STS_EV_EXT, STS_EV_LINK};
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int n;
    int exp_q [$];
    always #2 clk_sys = ~clk_sys;
    sts_sequencer u_dut (.CLK_SYS_I(clk_sys), .RST_I(rst), .CHAN_LIST_I(chan_list),
        .CLOSE_CMD_I(cmds[3]), .OPEN_CMD_I(cmds[2]), .OPEN_ALL_CMD_I(cmds[1]),
        .INIT_CMD_I(cmds[0]), .EVENTS_I(events), .CFG_I(cfg), .LIST_WE_I(list_we),
        .LIST_WADDR_I(list_waddr), .LIST_WDATA_I(list_wdata), .LIST_LEN_I(list_len),
        .RELAY_O(relay), .ARMED_O(armed), .LAYER_O(layer), .SCAN_IDX_O(scan_idx),
        .CHAN_READY_O(chan_ready));
    sts_event_src u_src (.clk_i(clk_sys), .fire_i(fire), .kind_i(kind), .ev_o(events));
    task automatic check(input logic [`STS_NCH-1:0] seen, input logic [`STS_NCH-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask : tick
    task automatic cmd(input logic [3:0] v);
        @(posedge clk_sys);
        cmds <= v;
        @(posedge clk_sys);
        cmds <= 4'h0;
    endtask : cmd
    task automatic pulse_ev(input sts_ev_t k);
        @(posedge clk_sys);
        kind <= k;
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
    endtask : pulse_ev
    task automatic set_cfg(input sts_ev_t a, input sts_ev_t s, input sts_ev_t c, input logic inf);
        sts_cfg_t v;
        v = '0;
        v.arm_ev = a;
        v.scan_ev = s;
        v.chan_ev = c;
        v.chan_inf = inf;
        v.arm_cnt = 14'h0002;
        v.scan_cnt = 14'h0002;
        v.chan_cnt = 14'h0002;
        @(posedge clk_sys);
        cfg <= v;
    endtask : set_cfg
    task automatic abort_chk();
        cmd(4'h2);
        tick(3);
        check(relay, '0);
        check(80'(armed), '0);
    endtask : abort_chk
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    always @(posedge clk_sys) begin
        cycles++;
        // generous against the few hundred cycles the scenarios need
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    initial begin
        {cmds, fire, list_we, list_waddr, list_wdata} = '0;
        chan_list = '0;
        cfg = '0;
        kind = STS_EV_IMMED;
        list_len = 7'h01;
        seed = 32'h0001_3E95;
        tick(8);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            list_we <= 1'b1;
            list_waddr <= 7'(i);
            list_wdata <= lst[i];
        end
        @(posedge clk_sys);
        list_we <= 1'b0;
        list_len <= 7'h03;
        foreach (lst[j]) exp_q.push_back(int'(lst[j]));
        exp_relay = '0;
        for (int r = 0; r < 6; r++) begin
            seed = lfsr(seed);
            nl = {seed[15:0], seed, lfsr(seed)};
            @(posedge clk_sys);
            chan_list <= nl;
            exp_relay = r[0] ? exp_relay & ~nl : exp_relay | nl;
            cmd(r[0] ? 4'h4 : 4'h8);
            tick(3);
            check(relay, exp_relay);
        end
        abort_chk();
        set_cfg(STS_EV_IMMED, STS_EV_IMMED, STS_EV_MANUAL, 1'b1);
        pulse_ev(STS_EV_MANUAL);
        tick(6);
        check(80'(armed), 80'h1);
        check(relay, '0);
        check(80'(layer), 80'h3);
        for (int k = 0; k < 4; k++) begin
            pulse_ev(STS_EV_MANUAL);
            for (int i = 0; i < 100 && chan_ready !== 1'b1; i++) @(posedge clk_sys);
            check(80'(chan_ready), 80'h1);
            check(relay, 80'h1 << exp_q[0]);
            exp_q.push_back(exp_q.pop_front());
            check(80'(scan_idx), 80'((k + 1) % 3));
        end
        abort_chk();
        for (int i = 0; i < 4; i++) begin
            set_cfg(arms[i], STS_EV_IMMED, STS_EV_HOLD, 1'b1);
            cmd(4'h1);
            tick(6);
            check(80'(layer), 80'h1);
            pulse_ev(arms[(i + 1) % 4]);
            tick(4);
            check(80'(layer), 80'h1);
            pulse_ev(arms[i]);
            tick(8);
            check(80'(layer), 80'h3);
            tick(20);
            check(80'(layer), 80'h3);
            abort_chk();
        end
        foreach (arms[m]) begin
            set_cfg(STS_EV_IMMED, m[0] ? STS_EV_TIMER : STS_EV_IMMED, STS_EV_IMMED, 1'b0);
            pulse_ev(STS_EV_MANUAL);
            n = 0;
            for (int i = 0; i < 800; i++) begin
                @(posedge clk_sys);
                n += (chan_ready === 1'b1);
                if (i > 4 && layer === 3'h0) break;
            end
            check(80'(n), 80'(2 * 2 * 2));
            check(80'(armed), '0);
        end
        report_and_stop();
    end
endmodule : sts_sequencer_bench
bind sts_sequencer sts_sequencer_assertions u_chk (.CLK_SYS_I, .RST_I, .CHAN_LIST_I,
    .CLOSE_CMD_I, .OPEN_CMD_I, .OPEN_ALL_CMD_I, .INIT_CMD_I, .EVENTS_I, .CFG_I, .LIST_WE_I,
    .LIST_WADDR_I, .LIST_WDATA_I, .LIST_LEN_I, .RELAY_O, .ARMED_O, .LAYER_O, .SCAN_IDX_O,
    .CHAN_READY_O);
